// file: cpsa_pkg.sv
package cpsa_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          PC_WIDTH     = 14;
    localparam int          PAGE_BITS    = 8;
    localparam int          PM_BYTES     = 8192;
    localparam int          DATA_W       = 8;
    localparam logic [13:0] PC_RST       = 14'h0000;
    localparam logic [7:0]  CSP_RST      = 8'h00;
    localparam logic [7:0]  DSP_RST      = 8'h00;
    localparam logic [7:0]  EP0_BUF_BASE = 8'hf8;

    // ------------------------------------------------------------
    // layout of the first saved call-stack byte
    // ------------------------------------------------------------
    localparam int SB_C_POS = 7;
    localparam int SB_Z_POS = 6;

    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ADD_IMM  = 8'h01;
    localparam logic [7:0] OP_ADD_DIR  = 8'h02;
    localparam logic [7:0] OP_ADD_IDX  = 8'h03;
    localparam logic [7:0] OP_MOVA_IMM = 8'h19;
    localparam logic [7:0] OP_MOVA_DIR = 8'h1a;
    localparam logic [7:0] OP_MOVA_IDX = 8'h1b;
    localparam logic [7:0] OP_MOVX_IMM = 8'h1c;
    localparam logic [7:0] OP_MOVX_DIR = 8'h1d;
    localparam logic [7:0] OP_PAGE_ADV = 8'h1f;
    localparam logic [7:0] OP_INC_X    = 8'h22;
    localparam logic [7:0] OP_POP_A    = 8'h2b;
    localparam logic [7:0] OP_POP_X    = 8'h2c;
    localparam logic [7:0] OP_PUSH_A   = 8'h2d;
    localparam logic [7:0] OP_PUSH_X   = 8'h2e;
    localparam logic [7:0] OP_SWAP_DSP = 8'h30;
    localparam logic [7:0] OP_ST_DIR   = 8'h31;
    localparam logic [7:0] OP_ST_IDX   = 8'h32;
    localparam logic [7:0] OP_SUB_RET  = 8'h3f;
    localparam logic [7:0] OP_MOV_A_X  = 8'h40;
    localparam logic [7:0] OP_MOV_X_A  = 8'h41;
    localparam logic [7:0] OP_SP_LOAD  = 8'h60;
    localparam logic [7:0] OP_INT_DIS  = 8'h70;
    localparam logic [7:0] OP_INT_ENA  = 8'h72;
    localparam logic [7:0] OP_INT_RET  = 8'h73;

    typedef enum logic [11:0] {
        S_FETCH = 12'h001,
        S_OP    = 12'h002,
        S_ARG   = 12'h004,
        S_MEM   = 12'h008,
        S_MRD   = 12'h010,
        S_DPUSH = 12'h020,
        S_DPOP  = 12'h040,
        S_CS1   = 12'h080,
        S_CS2   = 12'h100,
        S_RS1   = 12'h200,
        S_RS2   = 12'h400,
        S_RS3   = 12'h800
    } cpsa_state_t;

endpackage : cpsa_pkg

// file: cpsa_ptr_if.sv
`timescale 1ns/1ps
interface cpsa_ptr_if #(parameter int W = 8);
    logic         inc;
    logic         dec;
    logic         ld;
    logic [W-1:0] ld_val;
    logic [W-1:0] q;
    modport ctl (output inc, output dec, output ld, output ld_val, input q);
    modport ptr (input inc, input dec, input ld, input ld_val, output q);
endinterface : cpsa_ptr_if

// file: cpsa_ptr.sv
`timescale 1ns/1ps
module cpsa_ptr
    import cpsa_pkg::*;
#(
    parameter int           W   = 8,
    parameter logic [W-1:0] RST = '0
)(
    input  wire logic clk_in,
    input  wire logic rst_in,
    cpsa_ptr_if.ptr   p
);
    // ------------------------------------------------------------
    // stack pointer: load beats step, wraps modulo 2**W
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            p.q <= RST;
        else if (p.ld)
            p.q <= p.ld_val;
        else if (p.inc)
            p.q <= p.q + W'(1);
        else if (p.dec)
            p.q <= p.q - W'(1);
    end
endmodule : cpsa_ptr

// file: cpsa_agen.sv
`timescale 1ns/1ps
module cpsa_agen
    import cpsa_pkg::*;
#(
    parameter int W = DATA_W
)(
    input  wire logic [W-1:0] base_in,
    input  wire logic [W-1:0] index_in,
    input  wire logic         indexed_in,
    output logic      [W-1:0] ea_out
);
    // ------------------------------------------------------------
    // effective address; carry out is dropped on purpose
    // ------------------------------------------------------------
    wire logic [W-1:0] sum_w = base_in + index_in;
    assign ea_out = indexed_in ? sum_w : base_in;
endmodule : cpsa_agen

// file: cpsa_core.sv
`timescale 1ns/1ps
module cpsa_core
    import cpsa_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    output logic [PC_WIDTH-1:0]      pm_addr_out,
    input  wire logic [DATA_W-1:0]   pm_data_in,
    output logic [DATA_W-1:0]        ram_addr_out,
    output logic [DATA_W-1:0]        ram_wdata_out,
    output logic                     ram_we_out,
    input  wire logic [DATA_W-1:0]   ram_rdata_in,
    input  wire logic                irq_in,
    input  wire logic [PC_WIDTH-1:0] irq_vector_in,
    output logic                     irq_ack_out,
    output logic                     int_en_out,
    output logic [DATA_W-1:0]        acc_out,
    output logic [DATA_W-1:0]        index_out,
    output logic [DATA_W-1:0]        call_sp_out,
    output logic [DATA_W-1:0]        operand_sp_out,
    output logic                     carry_out,
    output logic                     zero_out,
    output logic                     ep0_access_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cpsa_state_t         state_r, state_nxt;
    logic [PC_WIDTH-1:0] pc_r, pc_nxt, tgt_r, tgt_nxt, pm_addr_r, pm_addr_nxt;
    logic [7:0]          ir_r, ir_nxt, arg_r, arg_nxt, acc_r, acc_nxt, x_r, x_nxt;
    logic [7:0]          ram_addr_r, ram_addr_nxt, ram_wd_r, ram_wd_nxt;
    logic                ram_we_r, ram_we_nxt, c_r, c_nxt, z_r, z_nxt;
    logic                ie_r, ie_nxt, ack_r, ack_nxt, ep_r, booted_r;
    logic                csp_inc, csp_dec, csp_ld, dsp_inc, dsp_dec, dsp_ld;

    cpsa_ptr_if #(.W(DATA_W)) csp_if ();
    cpsa_ptr_if #(.W(DATA_W)) dsp_if ();

    cpsa_ptr #(.W(DATA_W), .RST(CSP_RST)) u_csp (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .p      (csp_if.ptr)
    );

    cpsa_ptr #(.W(DATA_W), .RST(DSP_RST)) u_dsp (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .p      (dsp_if.ptr)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [7:0] op      = (state_r == S_OP) ? pm_data_in : ir_r;
    wire logic [3:0] grp     = op[7:4];
    wire logic       two_b   = (op >= OP_ADD_IMM && op <= OP_MOVX_DIR) ||
                               (op >= OP_ST_DIR && op <= 8'h39) ||
                               (op >= 8'h23 && op <= 8'h24) ||
                               (op >= 8'h27 && op <= 8'h2a) ||
                               grp == 4'h5 || op[7];
    wire logic       is_idx  = op == OP_ADD_IDX || op == OP_MOVA_IDX || op == OP_ST_IDX;
    wire logic       is_wr   = op == OP_ST_DIR || op == OP_ST_IDX;
    wire logic       is_rd   = is_idx || op == OP_ADD_DIR || op == OP_MOVA_DIR ||
                               op == OP_MOVX_DIR;
    wire logic       is_add  = op == OP_ADD_IMM || op == OP_ADD_DIR || op == OP_ADD_IDX;
    wire logic       dst_x   = op == OP_MOVX_IMM || op == OP_MOVX_DIR || op == OP_POP_X;
    wire logic       is_call = grp == 4'h9 || grp == 4'h5;
    wire logic       take    = grp == 4'h8 || (grp == 4'ha && z_r) ||
                               (grp == 4'hb && !z_r) || (grp == 4'hc && c_r) ||
                               (grp == 4'hd && !c_r);
    wire logic       is_interrupt_return_op = op == OP_INT_RET;
    // call/jump targets: 8x/9x low 4 KB, 5x upper 4 KB
    wire logic [PC_WIDTH-1:0] jt = {1'b0, ~op[7], op[3:0], pm_data_in};
    wire logic [7:0]  ld_src  = (state_r == S_MRD || state_r == S_DPOP) ?
                                ram_rdata_in : pm_data_in;
    wire logic [8:0]  sum     = {1'b0, acc_r} + {1'b0, ld_src};
    wire logic [7:0]  lo_inc  = pc_r[7:0] + 8'h01;
    wire logic [7:0]  byte1   = {c_r, z_r, pc_r[PC_WIDTH-1:PAGE_BITS]};
    wire logic        irq_go  = irq_in && ie_r;
    wire logic [7:0]  ea;

    cpsa_agen #(.W(DATA_W)) u_agen (
        .base_in    (arg_r),
        .index_in   (x_r),
        .indexed_in (is_idx),
        .ea_out     (ea)
    );

    assign csp_if.inc    = csp_inc;
    assign csp_if.dec    = csp_dec;
    assign csp_if.ld     = csp_ld;
    assign csp_if.ld_val = acc_r;
    assign dsp_if.inc    = dsp_inc;
    assign dsp_if.dec    = dsp_dec;
    assign dsp_if.ld     = dsp_ld;
    assign dsp_if.ld_val = acc_r;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r; pc_nxt = pc_r; tgt_nxt = tgt_r; pm_addr_nxt = pm_addr_r;
        ir_nxt = ir_r; arg_nxt = arg_r; acc_nxt = acc_r; x_nxt = x_r;
        ram_addr_nxt = ram_addr_r; ram_wd_nxt = ram_wd_r; ram_we_nxt = 1'b0;
        c_nxt = c_r; z_nxt = z_r; ie_nxt = ie_r; ack_nxt = 1'b0;
        csp_inc = 1'b0; csp_dec = 1'b0; csp_ld = 1'b0;
        dsp_inc = 1'b0; dsp_dec = 1'b0; dsp_ld = 1'b0;
        case (state_r)
            S_FETCH:
            begin
                if (irq_go)
                begin
                    ie_nxt    = 1'b0;
                    ack_nxt   = 1'b1;
                    tgt_nxt   = irq_vector_in;
                    state_nxt = S_CS1;
                end
                else
                begin
                    pm_addr_nxt = pc_r;
                    state_nxt   = S_OP;
                end
            end
            S_OP:
            begin
                ir_nxt    = pm_data_in;
                pc_nxt    = {pc_r[PC_WIDTH-1:PAGE_BITS], lo_inc};
                state_nxt = S_FETCH;
                if (two_b)
                begin
                    pm_addr_nxt = {pc_r[PC_WIDTH-1:PAGE_BITS], lo_inc};
                    state_nxt   = S_ARG;
                end
                else
                begin
                    case (op)
                        OP_PAGE_ADV: pc_nxt = {pc_r[PC_WIDTH-1:PAGE_BITS] + 6'h01, lo_inc};
                        OP_INC_X:    x_nxt = x_r + 8'h01;
                        OP_MOV_A_X:  acc_nxt = x_r;
                        OP_MOV_X_A:  x_nxt = acc_r;
                        OP_SP_LOAD:  csp_ld = 1'b1;
                        OP_SWAP_DSP:
                        begin
                            dsp_ld  = 1'b1;
                            acc_nxt = dsp_if.q;
                        end
                        OP_INT_DIS:  ie_nxt = 1'b0;
                        OP_INT_ENA:  ie_nxt = 1'b1;
                        OP_PUSH_A, OP_PUSH_X:
                        begin
                            dsp_dec   = 1'b1;
                            state_nxt = S_DPUSH;
                        end
                        OP_POP_A, OP_POP_X:
                        begin
                            ram_addr_nxt = dsp_if.q;
                            state_nxt    = S_DPOP;
                        end
                        OP_SUB_RET, OP_INT_RET:
                        begin
                            csp_dec   = 1'b1;
                            state_nxt = S_RS1;
                        end
                        default: state_nxt = S_FETCH;
                    endcase
                end
            end
            S_ARG:
            begin
                arg_nxt   = pm_data_in;
                pc_nxt    = {pc_r[PC_WIDTH-1:PAGE_BITS], lo_inc};
                state_nxt = S_FETCH;
                if (is_call)
                begin
                    tgt_nxt   = jt;
                    state_nxt = S_CS1;
                end
                else if (op[7])
                begin
                    if (take)
                        pc_nxt = jt;
                end
                else if (is_add)
                begin
                    if (op == OP_ADD_IMM)
                    begin
                        {c_nxt, acc_nxt} = sum;
                        z_nxt = sum[7:0] == 8'h00;
                    end
                    else
                        state_nxt = S_MEM;
                end
                else if (op == OP_MOVA_IMM)
                    acc_nxt = pm_data_in;
                else if (op == OP_MOVX_IMM)
                    x_nxt = pm_data_in;
                else if (is_rd || is_wr)
                    state_nxt = S_MEM;
            end
            S_MEM:
            begin
                ram_addr_nxt = ea;
                state_nxt    = is_wr ? S_FETCH : S_MRD;
                if (is_wr)
                begin
                    ram_we_nxt = 1'b1;
                    ram_wd_nxt = acc_r;
                end
            end
            S_MRD, S_DPOP:
            begin
                state_nxt = S_FETCH;
                if (state_r == S_DPOP)
                    dsp_inc = 1'b1;
                if (is_add)
                begin
                    {c_nxt, acc_nxt} = sum;
                    z_nxt = sum[7:0] == 8'h00;
                end
                else if (dst_x)
                    x_nxt = ld_src;
                else
                    acc_nxt = ld_src;
            end
            S_DPUSH:
            begin
                ram_addr_nxt = dsp_if.q;
                ram_wd_nxt   = (op == OP_PUSH_X) ? x_r : acc_r;
                ram_we_nxt   = 1'b1;
                state_nxt    = S_FETCH;
            end
            S_CS1, S_CS2:
            begin
                // pc_r already points past the call here, or at the next instruction to fetch on interrupt entry
                ram_addr_nxt = csp_if.q;
                ram_wd_nxt   = (state_r == S_CS1) ? byte1 : pc_r[7:0];
                ram_we_nxt   = 1'b1;
                csp_inc      = 1'b1;
                state_nxt    = (state_r == S_CS1) ? S_CS2 : S_FETCH;
                if (state_r == S_CS2)
                    pc_nxt = tgt_r;
            end
            S_RS1:
            begin
                ram_addr_nxt = csp_if.q;
                csp_dec      = 1'b1;
                state_nxt    = S_RS2;
            end
            S_RS2:
            begin
                pc_nxt[7:0]  = ram_rdata_in;
                ram_addr_nxt = csp_if.q;
                state_nxt    = S_RS3;
            end
            S_RS3:
            begin
                pc_nxt[PC_WIDTH-1:PAGE_BITS] = ram_rdata_in[PC_WIDTH-PAGE_BITS-1:0];
                state_nxt = S_FETCH;
                if (is_interrupt_return_op)
                begin
                    c_nxt  = ram_rdata_in[SB_C_POS];
                    z_nxt  = ram_rdata_in[SB_Z_POS];
                    ie_nxt = 1'b1;
                end
            end
            default: state_nxt = S_FETCH;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_r <= S_FETCH; pc_r <= PC_RST; tgt_r <= PC_RST;
            pm_addr_r <= PC_RST; ir_r <= 8'h00; arg_r <= 8'h00;
            acc_r <= 8'h00; x_r <= 8'h00; c_r <= 1'b0; z_r <= 1'b0;
            ram_addr_r <= 8'h00; ram_wd_r <= 8'h00; ram_we_r <= 1'b0;
            ie_r <= 1'b0; ack_r <= 1'b0; ep_r <= 1'b0; booted_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt; pc_r <= pc_nxt; tgt_r <= tgt_nxt;
            pm_addr_r <= pm_addr_nxt; ir_r <= ir_nxt; arg_r <= arg_nxt;
            acc_r <= acc_nxt; x_r <= x_nxt; c_r <= c_nxt; z_r <= z_nxt;
            ram_addr_r <= ram_addr_nxt; ram_wd_r <= ram_wd_nxt; ram_we_r <= ram_we_nxt;
            ie_r <= ie_nxt; ack_r <= ack_nxt;
            ep_r <= ram_addr_nxt >= EP0_BUF_BASE;
            booted_r <= booted_r || state_r == S_OP;
        end
    end

    // pc reaches outputs only as the fetch address and as the saved call-stack bytes on ram_wdata_out
    assign pm_addr_out    = pm_addr_r;
    assign ram_addr_out   = ram_addr_r;
    assign ram_wdata_out  = ram_wd_r;
    assign ram_we_out     = ram_we_r;
    assign irq_ack_out    = ack_r;
    assign int_en_out     = ie_r;
    assign acc_out        = acc_r;
    assign index_out      = x_r;
    assign call_sp_out    = csp_if.q;
    assign operand_sp_out = dsp_if.q;
    assign carry_out      = c_r;
    assign zero_out       = z_r;
    assign ep0_access_out = ep_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_BOOT_ZERO: assert property (!booted_r |-> pm_addr_r == 14'h0000)
        else $error("first fetch not at zero");
    AST_PAGE_HOLD: assert property (state_r == S_OP && !two_b && op != OP_PAGE_ADV
        |=> pc_r[13:8] == $past(pc_r[13:8]))
        else $error("upper pc bits moved without page op");
    AST_PAGE_ADV: assert property (state_r == S_OP && op == OP_PAGE_ADV
        |=> pc_r[13:8] == $past(pc_r[13:8]) + 6'h01)
        else $error("page op did not advance upper bits");
    AST_INT_ENTRY: assert property (state_r == S_FETCH && irq_go
        |=> !ie_r && irq_ack_out ##1 ram_we_out && ram_addr_out == $past(call_sp_out, 2))
        else $error("interrupt entry sequence wrong");
    AST_CALL_TWO: assert property (state_r == S_CS1
        |=> ##1 call_sp_out == $past(call_sp_out, 2) + 8'h02)
        else $error("call stack pointer not plus two");
    AST_RET_FLAGS: assert property (state_r == S_RS3 && !is_interrupt_return_op
        |=> c_r == $past(c_r) && z_r == $past(z_r))
        else $error("plain return changed flags");
    AST_INTERRUPT_RETURN_OP_IE: assert property (state_r == S_RS3 && is_interrupt_return_op
        |=> ie_r && c_r == $past(ram_rdata_in[SB_C_POS]))
        else $error("interrupt return did not restore");
    AST_SP_LOAD: assert property (state_r == S_OP && op == OP_SP_LOAD
        |=> call_sp_out == $past(acc_r))
        else $error("call pointer load failed");
    AST_PUSH_ORDER: assert property (state_r == S_OP
        && (op == OP_PUSH_A || op == OP_PUSH_X)
        |=> ##1 ram_we_out && ram_addr_out == $past(operand_sp_out, 2) - 8'h01)
        else $error("push did not pre-decrement");
    AST_POP_INC: assert property (state_r == S_DPOP
        |=> operand_sp_out == $past(operand_sp_out) + 8'h01)
        else $error("pop did not post-increment");
    AST_INDEXED: assert property (state_r == S_MEM && is_idx
        |=> ram_addr_out == 8'($past(arg_r) + $past(x_r)))
        else $error("indexed address wrong");

    COV_CALL: cover property (state_r == S_CS2 ##1 state_r == S_FETCH);
    COV_INTERRUPT_RETURN_OP: cover property (state_r == S_RS3 && is_interrupt_return_op);
    COV_PUSH_WRAP: cover property (state_r == S_DPUSH && operand_sp_out == 8'hff);
    COV_INT: cover property (state_r == S_FETCH && irq_go);

endmodule : cpsa_core

// file: cpsa_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// program rom and data ram partner
// ----------------------------------------
// comb rom and comb ram read; unloaded rom bytes read as a one-byte op
module cpsa_mem
    import cpsa_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic [PC_WIDTH-1:0] pm_addr_in,
    output logic      [DATA_W-1:0]   pm_data_out,
    input  wire logic [DATA_W-1:0]   ram_addr_in,
    input  wire logic [DATA_W-1:0]   ram_wdata_in,
    input  wire logic                ram_we_in,
    output logic      [DATA_W-1:0]   ram_rdata_out
);
    logic [7:0] rom [0:PM_BYTES-1];
    logic [7:0] ram [0:255];
    initial
    begin
        for (int i = 0; i < PM_BYTES; i++) rom[i] = 8'h20;
        for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    end
    assign pm_data_out   = rom[pm_addr_in[12:0]];
    assign ram_rdata_out = ram[ram_addr_in];
    always @(posedge clk_in)
    begin
        if (ram_we_in === 1'b1) ram[ram_addr_in] <= ram_wdata_in;
    end
endmodule : cpsa_mem

// file: cpu_pc_stack_addressing_tb_top.sv
`timescale 1ns/1ps
module cpu_pc_stack_addressing_tb_top;
    import cpsa_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in;
    logic [13:0] pm_addr, irq_vector_in;
    logic [7:0]  pm_data, ram_addr, ram_wdata, ram_rdata, acc, idx, csp, dsp, r, s, t;
    logic        ram_we, irq_in, irq_ack, int_en, carry, zero, ep0;
    logic [15:0] exp_q[$];
    logic [15:0] exp_v;
    logic [31:0] seed;
    int          n_fail = 0;
    int          checks = 0;
    logic [23:0] prog [0:60] = '{
        24'h0000_19, 24'h0001_5a, 24'h0002_31, 24'h0003_10, 24'h0004_2d, 24'h0005_1c,
        24'h0006_fe, 24'h0007_32, 24'h0008_05, 24'h0009_01, 24'h000a_00, 24'h000b_31,
        24'h000c_11, 24'h000d_90, 24'h000e_40, 24'h000f_2e, 24'h0010_2b, 24'h0011_31,
        24'h0012_12, 24'h0013_90, 24'h0014_48, 24'h0040_31, 24'h0041_13, 24'h0042_3f,
        24'h0048_80, 24'h0049_ff, 24'h00ff_1f, 24'h0100_19, 24'h0101_30, 24'h0102_60,
        24'h0103_90, 24'h0104_50, 24'h0050_72, 24'h0051_80, 24'h0052_51, 24'h0060_1b,
        24'h0061_15, 24'h0062_02, 24'h0063_10, 24'h0064_31, 24'h0065_14, 24'h0066_22,
        24'h0067_40, 24'h0068_2c, 24'h0069_30, 24'h006a_2e, 24'h006b_1d, 24'h006c_11,
        24'h006d_2d, 24'h006e_19, 24'h006f_30, 24'h0070_01, 24'h0071_d0, 24'h0072_70,
        24'h0073_d0, 24'h0074_51, 24'h0075_a0, 24'h0076_79, 24'h0077_31, 24'h0078_16,
        24'h0079_73};
    always #2.5 clk_in = ~clk_in;
    cpsa_core i_dut (.clk_in(clk_in), .rst_in(rst_in), .pm_addr_out(pm_addr),
        .pm_data_in(pm_data), .ram_addr_out(ram_addr), .ram_wdata_out(ram_wdata),
        .ram_we_out(ram_we), .ram_rdata_in(ram_rdata), .irq_in(irq_in),
        .irq_vector_in(irq_vector_in), .irq_ack_out(irq_ack), .int_en_out(int_en),
        .acc_out(acc), .index_out(idx), .call_sp_out(csp), .operand_sp_out(dsp),
        .carry_out(carry), .zero_out(zero), .ep0_access_out(ep0));
    cpsa_mem i_mem (.clk_in(clk_in), .pm_addr_in(pm_addr), .pm_data_out(pm_data),
        .ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata), .ram_we_in(ram_we),
        .ram_rdata_out(ram_rdata));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_fail, checks);
        if (n_fail == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic give_up(input logic ok);
        if (!ok)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask : give_up
    // ----------------------------------------
    // monitor: each ram write takes the oldest note
    // ----------------------------------------
    // falling edge: the registered strobe has settled, no race with its launch
    always @(negedge clk_in)
    begin
        if (ram_we === 1'b1)
        begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
            check({ram_addr, ram_wdata}, exp_v);
            check({15'h0, ep0}, {15'h0, ram_addr >= EP0_BUF_BASE});
        end
    end
    // ----------------------------------------
    // driver
    // ----------------------------------------
    initial
    begin
        rst_in = 1'b1;
        irq_in = 1'b0;
        irq_vector_in = 14'h0060;
        seed = lfsr(32'ha72b);
        r = {1'b0, seed[6:0]};  // kept below 0x80 so the add never carries
        s = 8'h5a + r;
        t = s + 8'h5a;
        #1;
        foreach (prog[i]) i_mem.rom[prog[i][23:8]] = prog[i][7:0];
        i_mem.rom[10] = r;
        // isr also runs direct, indexed, pop x, swap and conditional jumps
        exp_q = '{16'h105a, 16'hff5a, 16'h035a, {8'h11, s}, 16'h0000, 16'h010f, {8'h13, s},
            16'hfefe, 16'h12fe, 16'h0000, 16'h0115, 16'h3001, 16'h3105, 16'h3200, 16'h3351,
            {8'h14, t}, 16'hfe5a, 16'hfd00};
        repeat (4) @(negedge clk_in);
        check({2'b00, pm_addr}, 16'h0000);
        rst_in = 1'b0;
        for (int i = 0; i < 2000 && pm_addr !== 14'h0051; i++) @(negedge clk_in);
        give_up(pm_addr === 14'h0051);
        irq_in = 1'b1;
        for (int i = 0; i < 200 && irq_ack !== 1'b1; i++) @(negedge clk_in);
        give_up(irq_ack === 1'b1);
        check({15'h0, int_en}, 16'h0000);
        irq_in = 1'b0;
        for (int i = 0; i < 200 && int_en !== 1'b1; i++) @(negedge clk_in);
        give_up(int_en === 1'b1);
        repeat (4) @(negedge clk_in);
        check({14'h0, carry, zero}, 16'h0000);
        check({csp, dsp}, 16'h32fd);
        check({acc, idx}, {8'h00, s});
        check(16'(exp_q.size()), 16'h0000);
        report_and_stop();
    end
endmodule : cpu_pc_stack_addressing_tb_top
